// File: src/rssi_pwm_pkg.sv
package rssi_pwm_pkg;

   // clock and time base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STEP_TIME_NS = 208_000;
   localparam int unsigned PERIOD_TIME_NS = 8_320_000;
   localparam int unsigned MS_TIME_NS = 1_000_000;
   localparam int unsigned HOLD_UNIT_NS = 100_000_000;
   localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned HOLD_TICK_CYCLES = HOLD_UNIT_NS / CLK_PERIOD_NS;
   localparam int unsigned PERIOD_STEPS = PERIOD_TIME_NS / STEP_TIME_NS;

   // duty steps
   localparam logic [5:0] STEP_COUNT = 6'h28;
   localparam logic [5:0] MAX_STEP = 6'h26;
   localparam logic [7:0] STEP_BASE = 8'h0d;
   localparam logic [7:0] STEP_SLOPE_NUM = 8'h03;
   localparam logic [7:0] STEP_SLOPE_DEN = 8'h05;

   // signal level range
   localparam logic [5:0] LEVEL_MIN = 6'h06;
   localparam logic [5:0] LEVEL_MAX = 6'h36;

   // hold setting
   localparam logic [7:0] HOLD_OFF = 8'h00;
   localparam logic [7:0] HOLD_MAX = 8'h7f;
   localparam logic [7:0] HOLD_FOREVER = 8'hff;

   // strap capture
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic RESET_DUTY_HIGH = 1'b0;

   typedef enum logic [1:0] {
      ST_SYNC = 2'b00,
      ST_LISTEN = 2'b01,
      ST_DRIVE = 2'b11,
      ST_OFF = 2'b10
   } pin_state_type;

   // level above sensitivity to duty step, saturating
   function automatic logic [5:0] level_to_step(input logic [5:0] level);
      logic [7:0] db;
      logic [7:0] step;
      db = 8'h00;
      step = 8'h00;
      if (level > LEVEL_MIN) begin
         db = {2'b00, level - LEVEL_MIN};
         step = STEP_BASE + (db * STEP_SLOPE_NUM) / STEP_SLOPE_DEN;
         if (step > {2'b00, MAX_STEP})
            step = {2'b00, MAX_STEP};
      end
      return step[5:0];
   endfunction

   // hold setting above the range clamps to the maximum
   function automatic logic [6:0] hold_units(input logic [7:0] hold);
      logic [7:0] h;
      h = (hold > HOLD_MAX) ? HOLD_MAX : hold;
      return h[6:0];
   endfunction

endpackage

// File: src/rssi_pwm_core.sv
`timescale 1ns/1ps
module rssi_pwm_core #(
   parameter int unsigned STEP_CYC = rssi_pwm_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // duty request
   input wire logic [5:0] duty_i,
   // waveform
   output logic pwm_high_o,
   output logic period_start_o,
   output logic [5:0] duty_lat_o
);
   logic [23:0] pre_reg;
   logic [5:0] step_reg;
   logic [5:0] duty_reg;
   logic high_reg;
   logic [5:0] cur_duty;

   assign period_start_o = (pre_reg == 24'h000000) && (step_reg == 6'h00);
   assign cur_duty = period_start_o ? duty_i : duty_reg;

   // fixed period, independent of duty
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pre_reg <= 24'h000000;
         step_reg <= 6'h00;
      end else if (pre_reg == 24'(STEP_CYC - 1)) begin
         pre_reg <= 24'h000000;
         if (step_reg == rssi_pwm_pkg::STEP_COUNT - 6'h01)
            step_reg <= 6'h00;
         else
            step_reg <= step_reg + 6'h01;
      end else begin
         pre_reg <= pre_reg + 24'h000001;
      end
   end

   // duty taken once per period, high first
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         duty_reg <= 6'h00;
         high_reg <= rssi_pwm_pkg::RESET_DUTY_HIGH;
      end else begin
         if (period_start_o)
            duty_reg <= duty_i;
         high_reg <= step_reg < cur_duty;
      end
   end

   assign pwm_high_o = high_reg;
   assign duty_lat_o = duty_reg;
endmodule // rssi_pwm_core

// File: src/rssi_hold_timer.sv
`timescale 1ns/1ps
module rssi_hold_timer #(
   parameter int unsigned TICK_CYC = rssi_pwm_pkg::HOLD_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // control
   input wire logic load_i,
   input wire logic [7:0] hold_i,
   // status
   output logic expired_o
);
   logic [23:0] tick_reg;
   logic [6:0] count_reg;
   logic forever_reg;

   // restart on every captured packet
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         tick_reg <= 24'h000000;
         count_reg <= 7'h00;
         forever_reg <= 1'b0;
      end else if (load_i) begin
         tick_reg <= 24'h000000;
         count_reg <= rssi_pwm_pkg::hold_units(hold_i);
         forever_reg <= hold_i == rssi_pwm_pkg::HOLD_FOREVER;
      end else if (count_reg != 7'h00) begin
         if (tick_reg == 24'(TICK_CYC - 1)) begin
            tick_reg <= 24'h000000;
            count_reg <= count_reg - 7'h01;
         end else begin
            tick_reg <= tick_reg + 24'h000001;
         end
      end
   end

   assign expired_o = (count_reg == 7'h00) && !forever_reg;
endmodule // rssi_hold_timer

// File: src/rssi_pwm_indicator.sv
`timescale 1ns/1ps
module rssi_pwm_indicator #(
   parameter int unsigned STEP_CYC = rssi_pwm_pkg::STEP_CYCLES,
   parameter int unsigned MS_CYC = rssi_pwm_pkg::MS_CYCLES,
   parameter int unsigned TICK_CYC = rssi_pwm_pkg::HOLD_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // configuration
   input wire logic [7:0] signal_pwm_hold_time_i,
   // received packet
   input wire logic pkt_valid_i,
   input wire logic [5:0] last_packet_signal_level_i,
   // shared pin
   input wire logic config_pin_i,
   output logic config_pin_o,
   output logic config_pin_oe_o,
   // strap result
   output logic command_mode_o,
   output logic strap_done_o
);
   rssi_pwm_pkg::pin_state_type state_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic pin_filt_reg;
   logic [1:0] settle_reg;
   logic [23:0] ms_pre_reg;
   logic [6:0] ms_cnt_reg;
   logic [5:0] duty_reg;
   logic seen_reg;
   logic out_reg;
   logic oe_reg;
   logic cmd_reg;
   logic done_reg;
   logic expired;
   logic pwm_high;
   logic period_start;
   logic [5:0] duty_lat;
   logic show;
   logic [5:0] duty_shown;
   logic hold_on;
   logic pin_filt_next;

   assign hold_on = signal_pwm_hold_time_i != rssi_pwm_pkg::HOLD_OFF;
   assign pin_filt_next = (sync2_reg == sync3_reg) ? sync3_reg : pin_filt_reg;
   assign show = seen_reg && !expired && hold_on;
   assign duty_shown = show ? duty_reg : 6'h00;

   // pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
         pin_filt_reg <= 1'b1;
      end else begin
         sync1_reg <= config_pin_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_filt_reg <= pin_filt_next;
      end
   end

   // packet capture
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         duty_reg <= 6'h00;
         seen_reg <= 1'b0;
      end else if (pkt_valid_i) begin
         duty_reg <= rssi_pwm_pkg::level_to_step(
            last_packet_signal_level_i);
         seen_reg <= 1'b1;
      end
   end

   // pin direction sequence
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_reg <= rssi_pwm_pkg::ST_SYNC;
         settle_reg <= 2'h0;
         ms_pre_reg <= 24'h000000;
         ms_cnt_reg <= 7'h00;
         cmd_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         // input-time milliseconds run from reset release
         if (ms_pre_reg == 24'(MS_CYC - 1)) begin
            ms_pre_reg <= 24'h000000;
            if (ms_cnt_reg != rssi_pwm_pkg::HOLD_MAX[6:0])
               ms_cnt_reg <= ms_cnt_reg + 7'h01;
         end else begin
            ms_pre_reg <= ms_pre_reg + 24'h000001;
         end
         case (state_reg)
            rssi_pwm_pkg::ST_SYNC: begin
               if (settle_reg == rssi_pwm_pkg::STRAP_SETTLE) begin
                  // filter's next value, stage three has only just settled
                  cmd_reg <= !pin_filt_next;
                  done_reg <= 1'b1;
                  state_reg <= rssi_pwm_pkg::ST_LISTEN;
               end else begin
                  settle_reg <= settle_reg + 2'h1;
               end
            end
            rssi_pwm_pkg::ST_LISTEN: begin
               if (!hold_on)
                  state_reg <= rssi_pwm_pkg::ST_OFF;
               else if (ms_cnt_reg >= rssi_pwm_pkg::hold_units(
                     signal_pwm_hold_time_i))
                  state_reg <= rssi_pwm_pkg::ST_DRIVE;
            end
            rssi_pwm_pkg::ST_DRIVE: begin
               if (!hold_on)
                  state_reg <= rssi_pwm_pkg::ST_OFF;
            end
            rssi_pwm_pkg::ST_OFF: begin
               if (hold_on)
                  state_reg <= rssi_pwm_pkg::ST_LISTEN;
            end
            default: state_reg <= rssi_pwm_pkg::ST_SYNC;
         endcase
      end
   end

   // pin drive
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= (state_reg == rssi_pwm_pkg::ST_DRIVE) && hold_on;
         out_reg <= (state_reg == rssi_pwm_pkg::ST_DRIVE) && show
            && pwm_high;
      end
   end

   rssi_pwm_core #(
      .STEP_CYC(STEP_CYC)
   ) u_core (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .duty_i(duty_shown),
      .pwm_high_o(pwm_high),
      .period_start_o(period_start),
      .duty_lat_o(duty_lat)
   );

   rssi_hold_timer #(
      .TICK_CYC(TICK_CYC)
   ) u_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .load_i(pkt_valid_i),
      .hold_i(signal_pwm_hold_time_i),
      .expired_o(expired)
   );

   assign config_pin_o = out_reg;
   assign config_pin_oe_o = oe_reg;
   assign command_mode_o = cmd_reg;
   assign strap_done_o = done_reg;

   // helper counters for period and high-time checks
   logic [31:0] per_cnt;
   logic [31:0] high_cnt;
   logic [5:0] prev_duty;
   logic first_seen;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         per_cnt <= 32'h00000000;
         high_cnt <= 32'h00000000;
         prev_duty <= 6'h00;
         first_seen <= 1'b0;
      end else if (period_start) begin
         per_cnt <= 32'h00000000;
         high_cnt <= 32'h00000000;
         prev_duty <= duty_shown;
         first_seen <= 1'b1;
      end else begin
         per_cnt <= per_cnt + 32'h00000001;
         high_cnt <= high_cnt + {31'h00000000, pwm_high};
      end
   end

   a_period_fixed: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      period_start && first_seen |->
      per_cnt == 32'(STEP_CYC * rssi_pwm_pkg::PERIOD_STEPS - 1))
      else $error("pwm period length wrong");

   a_high_steps: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      period_start && first_seen |->
      high_cnt + {31'h00000000, pwm_high} ==
      32'(prev_duty) * 32'(STEP_CYC))
      else $error("high time not a whole number of steps");

   a_duty_ceiling: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      duty_lat <= rssi_pwm_pkg::MAX_STEP)
      else $error("duty above ninety five percent");

   a_duty_saturate: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && last_packet_signal_level_i == rssi_pwm_pkg::LEVEL_MAX
      |=> duty_reg == rssi_pwm_pkg::MAX_STEP)
      else $error("strongest packet not at top step");

   a_zero_weak: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && last_packet_signal_level_i <= rssi_pwm_pkg::LEVEL_MIN
      |=> duty_reg == 6'h00)
      else $error("weak packet gave non-zero duty");

   a_chart_low: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && last_packet_signal_level_i == 6'h10
      |=> duty_reg == 6'h13)
      else $error("10 dB point not 47.5 percent");

   a_chart_point: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && last_packet_signal_level_i == 6'h1a
      |=> duty_reg == 6'h19)
      else $error("20 dB point not 62.5 percent");

   a_chart_high: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && last_packet_signal_level_i == 6'h24
      |=> duty_reg == 6'h1f)
      else $error("30 dB point not 77.5 percent");

   a_high_first: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      period_start && duty_shown != 6'h00 |=> pwm_high [*1])
      else $error("period did not start high");

   a_hold_off: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      !hold_on [*2] |=> !config_pin_oe_o)
      else $error("pin driven with hold off");

   a_expired_low: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      expired |=> !config_pin_o)
      else $error("output high after hold expiry");

   a_forever_on: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && signal_pwm_hold_time_i == rssi_pwm_pkg::HOLD_FOREVER
      |=> !expired)
      else $error("permanent hold timed out");

   a_low_unseen: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      !seen_reg |=> !config_pin_o)
      else $error("output high before any packet");

   a_strap_held: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      done_reg |=> done_reg && $stable(cmd_reg))
      else $error("strap result changed after capture");

   a_input_early: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      state_reg != rssi_pwm_pkg::ST_DRIVE |=> !config_pin_oe_o)
      else $error("pin driven during input phase");

   a_drive_out: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      state_reg == rssi_pwm_pkg::ST_DRIVE && hold_on |=> config_pin_oe_o)
      else $error("pin not turned to output");

   a_listen_time: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      state_reg == rssi_pwm_pkg::ST_LISTEN && hold_on &&
      ms_cnt_reg < rssi_pwm_pkg::hold_units(signal_pwm_hold_time_i)
      |=> state_reg != rssi_pwm_pkg::ST_DRIVE)
      else $error("pin turned output too early");

   a_reload_hold: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      pkt_valid_i && hold_on |=> !expired)
      else $error("packet did not restart hold");

endmodule // rssi_pwm_indicator

// File: verification/rssi_pin_observer.sv
`timescale 1ns/1ps
module rssi_pin_observer (
   // clock
   input wire logic clk_i,
   // pin parties
   input wire logic strap_i,
   input wire logic pin_drive_i,
   input wire logic pin_oe_i,
   // resolved pin and measurements
   output logic pin_o,
   output logic [15:0] period_o,
   output logic [15:0] high_o
);
   logic prev_reg = 1'b0;
   logic [15:0] cnt_reg = 16'h0000;
   logic [15:0] period_reg = 16'h0000;
   logic [15:0] high_reg = 16'h0000;

   // strap level held whenever the device is not driving
   assign pin_o = pin_oe_i ? pin_drive_i : strap_i;
   assign period_o = period_reg;
   assign high_o = high_reg;

   // rise-to-rise distance and length of the high run
   always @(posedge clk_i) begin
      prev_reg <= pin_o;
      cnt_reg <= cnt_reg + 16'h0001;
      if (pin_o && !prev_reg) begin
         period_reg <= cnt_reg;
         cnt_reg <= 16'h0001;
      end
      if (!pin_o && prev_reg)
         high_reg <= cnt_reg;
   end
endmodule // rssi_pin_observer

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned STEP = 4;
   localparam int unsigned PER = 160;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] hold = 8'h03;
   logic pkt_valid = 1'b0;
   logic [5:0] level = 6'h00;
   logic strap = 1'b0;
   logic pin;
   logic pin_o;
   logic pin_oe;
   logic cmd_mode;
   logic strap_done;
   logic [15:0] period;
   logic [15:0] high_len;
   logic [15:0] highs;
   logic [31:0] seed = 32'h0000_0052;
   logic [5:0] corner [6] = '{6'h06, 6'h07, 6'h10, 6'h1a, 6'h24, 6'h36};
   int errors = 0;
   int compares = 0;
   int n;
   int total;

   always #5 clk_i = ~clk_i;

   rssi_pwm_indicator #(.STEP_CYC(4), .MS_CYC(10), .TICK_CYC(100)) DUT (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .signal_pwm_hold_time_i(hold),
      .pkt_valid_i(pkt_valid),
      .last_packet_signal_level_i(level),
      .config_pin_i(pin),
      .config_pin_o(pin_o),
      .config_pin_oe_o(pin_oe),
      .command_mode_o(cmd_mode),
      .strap_done_o(strap_done)
   );

   rssi_pin_observer observer (
      .clk_i(clk_i),
      .strap_i(strap),
      .pin_drive_i(pin_o),
      .pin_oe_i(pin_oe),
      .pin_o(pin),
      .period_o(period),
      .high_o(high_len)
   );

   // high cycles per period for a packet level
   function automatic logic [15:0] exp_high(input logic [5:0] l);
      int s;
      s = (l <= 6'h06) ? 0 : 13 + (int'(l) - 6) * 3 / 5;
      if (s > 38)
         s = 38;
      return 16'(s * STEP);
   endfunction

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      y = y ^ (y << 5);
      return y;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask

   task automatic send(input logic [5:0] l);
      @(posedge clk_i);
      pkt_valid <= 1'b1;
      level <= l;
      @(posedge clk_i);
      pkt_valid <= 1'b0;
   endtask

   task automatic count_high(input int k);
      highs = 16'h0000;
      repeat (k) begin
         @(posedge clk_i);
         #1;
         if (pin === 1'b1)
            highs = highs + 16'h0001;
      end
   endtask

   task automatic duty_case(input logic [5:0] l);
      send(l);
      tick(3 * PER);
      count_high(PER);
      check(highs, exp_high(l));
      if (exp_high(l) != 16'h0000) begin
         check(period, 16'(PER));
         check(high_len, exp_high(l));
      end
   endtask

   task automatic results;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      n = 0;
      while (pin_oe !== 1'b1 && n < 80) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 80) begin
         errors++;
         results();
      end
      check({15'h0000, n >= 28 && n <= 38}, 16'h0001);
      check({14'h0000, cmd_mode, strap_done}, 16'h0003);
      check({14'h0000, pin_oe, pin_o}, 16'h0002);
      count_high(PER);
      check(highs, 16'h0000);
      @(posedge clk_i);
      hold <= 8'hff;
      foreach (corner[i])
         duty_case(corner[i]);
      repeat (6) begin
         seed = xorshift(seed);
         duty_case(6'h06 + 6'(seed % 49));
      end
      // back-to-back packets, last one wins
      @(posedge clk_i);
      pkt_valid <= 1'b1;
      level <= 6'h36;
      @(posedge clk_i);
      level <= 6'h10;
      @(posedge clk_i);
      pkt_valid <= 1'b0;
      tick(3 * PER);
      count_high(PER);
      check(highs, exp_high(6'h10));
      // permanent hold outlasts the longest countdown
      tick(13000);
      count_high(PER);
      check(highs, exp_high(6'h10));
      // 200-cycle hold refreshed every 152 cycles
      @(posedge clk_i);
      hold <= 8'h02;
      send(6'h36);
      total = 0;
      repeat (4) begin
         count_high(150);
         total += highs;
         send(6'h36);
      end
      check({15'h0000, total >= 304}, 16'h0001);
      tick(250);
      count_high(PER);
      check(highs, 16'h0000);
      @(posedge clk_i);
      hold <= 8'h00;
      tick(4);
      check({15'h0000, pin_oe}, 16'h0000);
      results();
   end
endmodule // tb_top
